// [core/aslp_defs.vh]
// constants for the address strap and led pin block
`ifndef ASLP_DEFS_VH
`define ASLP_DEFS_VH
`define ASLP_CLK_MHZ        200
`define ASLP_STRETCH_MS     70
// stretch length in cycles: 70 ms at 200 MHz
`define ASLP_STRETCH_CYC    (`ASLP_STRETCH_MS * 1000 * `ASLP_CLK_MHZ)
`define ASLP_CNT_W          24
`define ASLP_ADDR1_BIT      1
`define ASLP_ADDR2_BIT      2
`endif

// [core/aslp_pins.v]
// dual-purpose address strap / status led pins (address bits 1 and 2)
//
// Contract
// - during power-on or hardware reset pins are inputs; level latched at reset end.
// - collision pin gives address bit 1, then drives collision status.
// - link pin gives address bit 2, then drives link status.
// - low pin latches address bit zero, high pin latches one.
// - collision pin asserted while collisions detected, else de-asserted.
// - each collision holds collision indicator asserted about 70 ms.
// - link pin asserted while link valid, de-asserted without link.
// - asserted output level is the inverse of the latched strap level.
// - software reset keeps pins outputs and does not resample straps.
`include "aslp_defs.vh"

module aslp_pins #(
    parameter STRETCH_CYC = `ASLP_STRETCH_CYC,
    parameter CNT_W       = `ASLP_CNT_W
) (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_soft_rst,
    input  wire       i_collision,
    input  wire       i_link_ok,
    input  wire       i_addr1_collision_pin_in,
    input  wire       i_addr2_link_pin_in,
    output reg        o_addr1_collision_pin_out,
    output reg        o_addr1_collision_pin_oe,
    output reg        o_addr2_link_pin_out,
    output reg        o_addr2_link_pin_oe,
    output reg  [4:0] o_addr_bits,
    output reg        o_addr_valid
);

    // timing, counted in edges after i_srst is first seen low:
    //   edge 1  straps taken from the pins, o_addr_valid rises
    //   edge 2  pins turn to outputs and show their indicators
    // a collision seen at edge c shows on the pin from edge c+1 and leaves
    // it at edge c+STRETCH_CYC+1; link status seen at edge c shows from edge c, one edge sooner

    // phases of the pin pair, one-hot: pins read as straps, then drive leds
    localparam [1:0]       ST_STRAP = 2'h1;
    localparam [1:0]       ST_DRIVE = 2'h2;

    // index of each pin inside the pair; collision pin is bit 0 everywhere
    localparam             PIN_COLL = 0;
    localparam             PIN_LINK = 1;
    localparam             NUM_PINS = 2;

    // stretch reload held 32 bits wide, then cut to the counter on purpose;
    // the counter must hold STRETCH_CYC-1, so CNT_W may not be made smaller
    localparam [31:0]      STRETCH_LOAD_W = STRETCH_CYC - 1;
    localparam [CNT_W-1:0] STRETCH_LOAD   = STRETCH_LOAD_W[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ZERO       = {CNT_W{1'h0}};
    localparam [CNT_W-1:0] CNT_ONE        = {{(CNT_W-1){1'h0}}, 1'h1};

    // phase register
    reg  [1:0]          state;
    reg  [1:0]          next_state;

    // collision stretch
    reg  [CNT_W-1:0]    stretch_cnt;
    reg  [CNT_W-1:0]    next_stretch_cnt;
    reg                 coll_ind;
    reg                 next_coll_ind;

    // per-pin views of the pair, indexed by PIN_COLL and PIN_LINK
    wire [NUM_PINS-1:0] pin_level;
    wire [NUM_PINS-1:0] pin_active;
    wire [NUM_PINS-1:0] pin_strap;
    wire [NUM_PINS-1:0] drv_out;
    wire [NUM_PINS-1:0] drv_oe;

    // led drive level: idle level equals the strap, so the led that sits
    // between pin and strap resistor sees no voltage and stays dark
    function led_level;
        input active;
        input strap;
        begin
            led_level = active ^ strap;
        end
    endfunction

    // true while the pin pair still belongs to the strap phase
    function in_strap_phase;
        input [1:0] phase;
        begin
            in_strap_phase = (phase == ST_STRAP);
        end
    endfunction

    // pin levels as read; once a pin drives, it reads back its own drive,
    // which is why nothing after the strap edge may look at these
    assign pin_level  = {i_addr2_link_pin_in, i_addr1_collision_pin_in};

    // indicator that each pin shows once it drives
    assign pin_active = {i_link_ok, coll_ind};

    // next phase; once driving, only a hardware reset brings the straps back,
    // so a software reset can neither resample nor turn the pins around
    always @* begin
        next_state = state;
        case (state)
            ST_STRAP: begin
                next_state = ST_DRIVE;
            end
            ST_DRIVE: begin
                next_state = ST_DRIVE;
            end
            default: begin
                next_state = ST_STRAP;
            end
        endcase
    end

    // phase register; reset parks the pins in the strap phase
    always @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_STRAP;
        end else begin
            state <= next_state;
        end
    end

    // address valid: set on the single strap edge, cleared only by reset
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_addr_valid <= 1'h0;
        end else if (in_strap_phase(state)) begin
            o_addr_valid <= 1'h1;
        end
    end

    // collision stretch; a collision reloads the count whether or not one is
    // already running, so the led outlasts the last collision, not the first
    always @* begin
        next_stretch_cnt = stretch_cnt;
        next_coll_ind    = coll_ind;
        if (i_collision) begin
            next_stretch_cnt = STRETCH_LOAD;
            next_coll_ind    = 1'h1;
        end else if (stretch_cnt != CNT_ZERO) begin
            next_stretch_cnt = stretch_cnt - CNT_ONE;
        end else begin
            next_coll_ind    = 1'h0;
        end
    end

    // stretch registers; the count keeps running in the strap phase, which is
    // harmless because the pins are not driven until that phase is over
    always @(posedge i_clk) begin
        if (i_srst) begin
            stretch_cnt <= CNT_ZERO;
            coll_ind    <= 1'h0;
        end else begin
            stretch_cnt <= next_stretch_cnt;
            coll_ind    <= next_coll_ind;
        end
    end

    // one strap latch and one driver per pin; i_soft_rst is ignored on
    // purpose, so neither strap nor direction changes outside a hard reset
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            reg strap_q;
            reg drv_q;
            reg oe_q;

            // strap latch: taken once, on the edge that leaves the strap
            // phase, so no port value enters the reset branch
            always @(posedge i_clk) begin
                if (i_srst) begin
                    strap_q <= 1'h0;
                end else if (in_strap_phase(state)) begin
                    strap_q <= pin_level[gi];
                end
            end

            // driver: released through reset and the strap edge, then on
            // for good; the level waits one edge for the strap to settle
            always @(posedge i_clk) begin
                if (i_srst) begin
                    oe_q  <= 1'h0;
                    drv_q <= 1'h0;
                end else if (!in_strap_phase(state)) begin
                    oe_q  <= 1'h1;
                    drv_q <= led_level(pin_active[gi], pin_strap[gi]);
                end
            end

            assign pin_strap[gi] = strap_q;
            assign drv_out[gi]   = drv_q;
            assign drv_oe[gi]    = oe_q;
        end
    endgenerate

    // address word: only bits 1 and 2 come from this pair, the rest read zero
    always @* begin
        o_addr_bits                  = 5'h00;
        o_addr_bits[`ASLP_ADDR1_BIT] = pin_strap[PIN_COLL];
        o_addr_bits[`ASLP_ADDR2_BIT] = pin_strap[PIN_LINK];
    end

    // pair back onto the named pins
    always @* begin
        o_addr1_collision_pin_out = drv_out[PIN_COLL];
        o_addr1_collision_pin_oe  = drv_oe[PIN_COLL];
        o_addr2_link_pin_out      = drv_out[PIN_LINK];
        o_addr2_link_pin_oe       = drv_oe[PIN_LINK];
    end

endmodule

// [tb/aslp_brd.sv]
// board model: strap resistor with an led in series on each pin
module aslp_brd (input wire logic [1:0] i_oe, i_drv, i_strap, output wire logic [1:0] o_pin);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin settles to its resistor, never holds the last driven level
    assign o_pin = (i_oe & i_drv) | (~i_oe & i_strap);
endmodule

// [tb/aslp_chk_checker.sv]
// assertions for the strap and led pins
module aslp_chk #(parameter STRETCH_CYC = 8) (input wire logic i_clk, i_srst, i_collision,
    i_link_ok, i_addr1_collision_pin_in, i_addr2_link_pin_in, o_addr1_collision_pin_out,
    o_addr1_collision_pin_oe, o_addr2_link_pin_out, o_addr2_link_pin_oe, o_addr_valid,
    input wire logic [4:0] o_addr_bits);
    timeunit 1ns;
    timeprecision 1ps;
    wire [4:0] a = o_addr_bits;
    wire [1:0] e = {o_addr2_link_pin_oe, o_addr1_collision_pin_oe};
    wire v = o_addr_valid, l = o_addr1_collision_pin_out ^ a[1], k = o_addr2_link_pin_out ^ a[2];
    int g;  // cycles since last collision; saturates so it never wraps back into the window
    always @(posedge i_clk) g <= i_srst ? 99 : i_collision ? 0 : g + (g < 99);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_lat; !v ##1 v; endsequence
    AST_IN: assert property (!$past(v) |-> !e) else $error("early drive");
    AST_OUT: assert property ($past(v) |-> &e) else $error("not driven");
    AST_ADR: assert property (s_lat |-> a[2:1] == $past({i_addr2_link_pin_in,
        i_addr1_collision_pin_in})) else $error("bad strap");
    AST_KEEP: assert property (v |=> $stable(a)) else $error("strap moved");
    AST_LNK: assert property (&e |-> k == $past(i_link_ok)) else $error("link led");
    AST_HIT: assert property (&e && i_collision |-> ##2 l) else $error("no hit");
    AST_ON: assert property (&e && g inside {[1:STRETCH_CYC]} |-> l) else $error("short");
    AST_OFF: assert property (&e && g > STRETCH_CYC |-> !l) else $error("stuck");
endmodule
bind aslp_pins aslp_chk #(.STRETCH_CYC(STRETCH_CYC)) chk_u (.*);

// [tb/test_addr_strap_led_pins.sv]
// bench for the address strap and led pins
module test_addr_strap_led_pins;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_srst = 1, i_soft_rst = 0, i_collision = 0, i_link_ok = 0;
    logic [1:0] s = 1;  // strap levels, bit 0 is the collision pin
    wire [1:0] q, e, p;
    wire [4:0] a;
    wire v;
    int num_errors, n_tests;
    aslp_pins #(.STRETCH_CYC(8)) dut_u (.i_clk, .i_srst, .i_soft_rst, .i_collision, .i_link_ok,
        .i_addr1_collision_pin_in(p[0]), .i_addr2_link_pin_in(p[1]), .o_addr_bits(a),
        .o_addr1_collision_pin_out(q[0]), .o_addr1_collision_pin_oe(e[0]), .o_addr_valid(v),
        .o_addr2_link_pin_out(q[1]), .o_addr2_link_pin_oe(e[1]));
    aslp_brd brd_u (.i_oe(e), .i_drv(q), .i_strap(s), .o_pin(p));
    initial forever #2.5 i_clk = ~i_clk;
    task chk(input logic [4:0] got, exp);  // every result here fits five bits
        n_tests++;
        if (got !== exp) begin num_errors++; $display("wrong value %0t got %h", $time, got); end
    endtask
    task step(input int n); repeat (n) @(negedge i_clk); endtask
    task end_sim;
        $display("compares %0d wrong %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task boot(input logic [1:0] st);  // hardware reset with new strap levels
        s = st; i_srst = 1; step(5); i_srst = 0; step(2);
        chk({a[2:1], e}, {st, 2'b11});
        chk({v, a[4:3], a[0]}, 4'h8);
        $display("strap test %b done", st);
    endtask
    task coll;  // second hit lands mid-stretch and must restart it
        i_collision = 1; step(1); i_collision = 0; step(4); i_collision = 1; step(1);
        i_collision = 0; step(8); chk(q[0], !s[0]);
        step(1); chk(q[0], s[0]);
        $display("collision test done");
    endtask
    task link;  // soft reset held throughout must leave pins and straps alone
        i_link_ok = 1; i_soft_rst = 1; step(2); chk(q[1], !s[1]);
        i_link_ok = 0; step(2); chk({a[2:1], e, q[1]}, {s, 2'b11, s[1]});
        i_soft_rst = 0; $display("link test done");
    endtask
    initial begin
        boot(2'b01); coll; link; boot(2'b10); coll; link; end_sim;
    end
endmodule
